/* hv_pkg.sv */
// package: constants for the high voltage pin protection block
package hv_pkg;
  // hv_pin_config_one fields
  localparam int CFG_OPEN_DIAG_BIT  = 0;
  localparam int CFG_WAKE_TO_OFF    = 1;
  localparam int CFG_PASSIVE_BIT    = 2;
  localparam int CFG_REENABLE_BIT   = 3;
  localparam int CFG_READBACK_BIT   = 4;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  // hv_live_monitor fields
  localparam int MON_WAKE_SC        = 0;
  localparam int MON_TEST_SC        = 1;
  localparam int MON_BUS_SC         = 2;
  localparam int MON_OVERTEMP       = 6;
  localparam int MON_TEST_READ      = 5;
  localparam int MON_WAKE_READ      = 7;
  localparam logic [7:0] MON_RESET  = 8'h00;
  // interrupt enable position in the core mask
  localparam int IRQ_EN_BIT         = 16;
  // indirect command codes
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_WRITE_CFG1 = 4'h1;
  localparam logic [3:0] CMD_READ_CFG1  = 4'h2;
  localparam logic [3:0] CMD_READ_MON   = 4'h3;
  // timing
  localparam int CLK_HZ             = 100_000_000;
  localparam int CLK_NS             = 10;
  localparam int BUS_SC_US          = 20;
  localparam int WAKE_SC_US         = 400;
  localparam int WAKE_TO_MS10       = 130;
  localparam int BUS_SC_CYC  = (BUS_SC_US * 1000) / CLK_NS;
  localparam int WAKE_SC_CYC = (WAKE_SC_US * 1000) / CLK_NS;
  localparam longint WAKE_TO_CYC = (longint'(WAKE_TO_MS10) * 10_000_000) / CLK_NS;
endpackage

/* hv_fault_qual.sv */
// short-circuit qualification timer for one pin
`timescale 1ns/1ns
module hv_fault_qual #(
  parameter int LIMIT = hv_pkg::BUS_SC_CYC
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic fault,
  output logic      faultEvent
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        event_reg;

  // [RQ17] restart on gap
  assign count_next = !fault ? 32'h0 :
                      (count_reg >= 32'(LIMIT)) ? count_reg : count_reg + 32'h1;

  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= 32'h0;
      event_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      // [RQ2] event only past limit
      event_reg <= fault && (count_reg == 32'(LIMIT) - 32'h1);
    end
  end
  assign faultEvent = event_reg;

  property p_rq17;
    @(posedge clock) disable iff (srst) !fault |=> count_reg == 32'h0;
  endproperty
  a_rq17: assert property (p_rq17) else $error("timer not restarted"); // [RQ17]
endmodule

/* hv_pin_protection_config.sv */
// high voltage pin protection configuration and live monitor
`timescale 1ns/1ns
// Operation
// [RQ1] re-enable strobe restores every driver shut by a short
// [RQ2] short counts only past 20 us bus/test, 400 us wake
// [RQ3] wake/test off by overtemperature return only on re-enable strobe
// [RQ4] short interrupt stays pending until re-enable strobe
// [RQ5] re-enable bit clears itself
// [RQ6] passive mode: bus short flags and interrupts, driver stays on
// [RQ7] interrupt reaches core only when mask bit 16 set
// [RQ8] active mode: bus short flags, interrupts, disables driver
// [RQ9] only re-enable strobe turns a disabled driver back on
// [RQ10] wake timeout bit set keeps wake asserted indefinitely
// [RQ11] timeout clear: wake drops 1.3 s after assertion
// [RQ12] diagnostic bit connects wake pull-up
// [RQ13] monitor is 8-bit read-only live view, resets to 00
// [RQ14] monitor reached only through indirect command and data
// [RQ15] bus and test short flags clear on re-enable strobe
// [RQ16] overtemperature turns off all drivers
// [RQ17] qualification timer restarts when fault ends early
module hv_pin_protection_config #(
  parameter longint WAKE_TO_CYC = hv_pkg::WAKE_TO_CYC
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        cmdValid,
  input  wire logic [3:0]  cmdCode,
  input  wire logic [7:0]  cmdWriteData,
  input  wire logic [31:0] interrupt_enable_mask,
  input  wire logic        wakeDriveReq,
  input  wire logic        busShort,
  input  wire logic        testShort,
  input  wire logic        wakeShort,
  input  wire logic        overTemp,
  input  wire logic        wakePinIn,
  input  wire logic        testPinIn,
  output logic [7:0]       hv_indirect_data,
  output logic             hv_core_interrupt,
  output logic             busDriverEn,
  output logic             testDriverEn,
  output logic             wakeDriverEn,
  output logic             wake_pin,
  output logic             wakePullUpEn
);
  // ************************************
  // pin synchronisers
  // ************************************
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  wire  sBus  = syncB_reg[0];
  wire  sTest = syncB_reg[1];
  wire  sWake = syncB_reg[2];
  wire  sOt   = syncB_reg[3];
  wire  sWIn  = syncB_reg[4];
  wire  sTIn  = syncB_reg[5];
  always_ff @(posedge clock) begin
    if (srst) begin
      syncA_reg <= 6'h00;
      syncB_reg <= 6'h00;
    end else begin
      syncA_reg <= {testPinIn, wakePinIn, overTemp, wakeShort, testShort, busShort};
      syncB_reg <= syncA_reg;
    end
  end

  // ************************************
  // qualification
  // ************************************
  logic busEv;
  logic testEv;
  logic wakeEv;
  // [RQ2] 20 us bus
  hv_fault_qual #(.LIMIT(hv_pkg::BUS_SC_CYC)) u_bus (
    .clock(clock), .srst(srst), .fault(sBus), .faultEvent(busEv));
  // [RQ2] 20 us test
  hv_fault_qual #(.LIMIT(hv_pkg::BUS_SC_CYC)) u_test (
    .clock(clock), .srst(srst), .fault(sTest), .faultEvent(testEv));
  // [RQ2] 400 us wake
  hv_fault_qual #(.LIMIT(hv_pkg::WAKE_SC_CYC)) u_wake (
    .clock(clock), .srst(srst), .fault(sWake), .faultEvent(wakeEv));

  // ************************************
  // indirect command decode
  // ************************************
  logic [7:0] cfg_reg;
  logic       reenable_reg;
  wire cfgWrite  = cmdValid && (cmdCode == hv_pkg::CMD_WRITE_CFG1);
  wire readCfg   = cmdValid && (cmdCode == hv_pkg::CMD_READ_CFG1);
  wire readMon   = cmdValid && (cmdCode == hv_pkg::CMD_READ_MON);
  wire strobeReq = cfgWrite && cmdWriteData[hv_pkg::CFG_REENABLE_BIT];
  wire passive   = cfg_reg[hv_pkg::CFG_PASSIVE_BIT];
  wire readback  = cfg_reg[hv_pkg::CFG_READBACK_BIT];

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_reg      <= hv_pkg::CFG_RESET;
      reenable_reg <= 1'b0;
    end else begin
      // [RQ5] strobe self-clears
      reenable_reg <= strobeReq;
      if (cfgWrite) begin
        cfg_reg <= cmdWriteData & ~(8'h01 << hv_pkg::CFG_REENABLE_BIT);
      end
    end
  end

  // ************************************
  // fault flags and driver enables
  // ************************************
  logic busSc_reg;
  logic testSc_reg;
  logic wakeSc_reg;
  logic ot_reg;
  logic busOff_reg;
  logic testOff_reg;
  logic wakeOff_reg;
  logic pend_reg;
  // [RQ15] flags clear on strobe, a new event wins
  wire busSc_next  = busEv  || (busSc_reg  && !reenable_reg);
  wire testSc_next = testEv || (testSc_reg && !reenable_reg);
  wire wakeSc_next = wakeEv || (wakeSc_reg && !reenable_reg);
  // [RQ8] active mode shuts bus driver
  // [RQ16] overtemperature shuts all drivers
  wire busOff_next  = (busEv && !passive) || sOt || (busOff_reg && !reenable_reg);
  // [RQ3] test/wake back only on strobe
  wire testOff_next = testEv || sOt || (testOff_reg && !reenable_reg);
  wire wakeOff_next = wakeEv || sOt || (wakeOff_reg && !reenable_reg);
  // [RQ4] pending until strobe, new event wins
  wire pend_next = busEv || testEv || wakeEv || (sOt && !ot_reg) || (pend_reg && !reenable_reg);

  always_ff @(posedge clock) begin
    if (srst) begin
      busSc_reg   <= 1'b0;
      testSc_reg  <= 1'b0;
      wakeSc_reg  <= 1'b0;
      ot_reg      <= 1'b0;
      busOff_reg  <= 1'b0;
      testOff_reg <= 1'b0;
      wakeOff_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end else begin
      busSc_reg   <= busSc_next;
      testSc_reg  <= testSc_next;
      wakeSc_reg  <= wakeSc_next;
      ot_reg      <= sOt;
      // [RQ1] [RQ9] strobe is the only release
      busOff_reg  <= busOff_next;
      testOff_reg <= testOff_next;
      wakeOff_reg <= wakeOff_next;
      pend_reg    <= pend_next;
    end
  end

  // ************************************
  // wake timeout
  // ************************************
  logic [31:0] wakeCnt_reg;
  logic        wakeOut_reg;
  logic        wakeReqD_reg;
  wire wakeRise  = wakeDriveReq && !wakeReqD_reg;
  wire toEnabled = !cfg_reg[hv_pkg::CFG_WAKE_TO_OFF];
  wire toHit     = toEnabled && (wakeCnt_reg == 32'(WAKE_TO_CYC) - 32'h1);
  always_ff @(posedge clock) begin
    if (srst) begin
      wakeCnt_reg  <= 32'h0;
      wakeOut_reg  <= 1'b0;
      wakeReqD_reg <= 1'b0;
    end else begin
      wakeReqD_reg <= wakeDriveReq;
      // [RQ10] [RQ11] monoflop counter
      if (!wakeDriveReq || wakeRise || !toEnabled) begin
        wakeCnt_reg <= 32'h0;
      end else if (wakeOut_reg) begin
        wakeCnt_reg <= wakeCnt_reg + 32'h1;
      end
      if (!wakeDriveReq || toHit) begin
        wakeOut_reg <= 1'b0;
      end else if (wakeRise || !toEnabled) begin
        wakeOut_reg <= 1'b1;
      end
    end
  end

  // ************************************
  // monitor and outputs
  // ************************************
  // [RQ13] live view of enabled circuits
  wire [7:0] monView = {readback && sWIn, ot_reg, readback && sTIn, 2'b00,
                        busSc_reg, testSc_reg, wakeSc_reg};
  logic [7:0] data_reg;
  logic       irq_reg;
  logic [4:0] outs_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      data_reg <= hv_pkg::MON_RESET;
      irq_reg  <= 1'b0;
      outs_reg <= 5'h00;
    end else begin
      // [RQ14] indirect read path
      if (readMon) begin
        data_reg <= monView;
      end else if (readCfg) begin
        data_reg <= cfg_reg;
      end
      // [RQ7] mask gate
      irq_reg  <= pend_reg && interrupt_enable_mask[hv_pkg::IRQ_EN_BIT];
      // [RQ6] [RQ12] driver and pull-up outputs
      outs_reg <= {!busOff_reg, !testOff_reg, !wakeOff_reg,
                   wakeOut_reg && !wakeOff_reg, cfg_reg[hv_pkg::CFG_OPEN_DIAG_BIT]};
    end
  end
  assign hv_indirect_data  = data_reg;
  assign hv_core_interrupt = irq_reg;
  assign busDriverEn       = outs_reg[4];
  assign testDriverEn      = outs_reg[3];
  assign wakeDriverEn      = outs_reg[2];
  assign wake_pin          = outs_reg[1];
  assign wakePullUpEn      = outs_reg[0];

  // ************************************
  // checks
  // ************************************
  property p_rq5;
    @(posedge clock) disable iff (srst)
      (reenable_reg && !strobeReq) |=> !reenable_reg && !cfg_reg[hv_pkg::CFG_REENABLE_BIT];
  endproperty
  a_rq5: assert property (p_rq5) else $error("strobe stuck"); // [RQ5]
  property p_rq6;
    @(posedge clock) disable iff (srst)
      (busEv && passive && !busOff_reg && !sOt) |=> !busOff_reg && busSc_reg;
  endproperty
  a_rq6: assert property (p_rq6) else $error("passive mode disabled driver"); // [RQ6]
  property p_rq8;
    @(posedge clock) disable iff (srst) (busEv && !passive) |=> busOff_reg && busSc_reg ##1 !busDriverEn;
  endproperty
  a_rq8: assert property (p_rq8) else $error("active mode kept driver"); // [RQ8]
  property p_rq9;
    @(posedge clock) disable iff (srst) (busOff_reg && !reenable_reg) |=> busOff_reg;
  endproperty
  a_rq9: assert property (p_rq9) else $error("driver released without strobe"); // [RQ9]
  property p_rq4;
    @(posedge clock) disable iff (srst) (pend_reg && !reenable_reg) |=> pend_reg;
  endproperty
  a_rq4: assert property (p_rq4) else $error("pending lost"); // [RQ4]
  property p_rq7;
    @(posedge clock) disable iff (srst)
      hv_core_interrupt |-> $past(pend_reg) && $past(interrupt_enable_mask[hv_pkg::IRQ_EN_BIT]);
  endproperty
  a_rq7: assert property (p_rq7) else $error("interrupt unmasked"); // [RQ7]
  property p_rq16;
    @(posedge clock) disable iff (srst) sOt |=> ##1 !busDriverEn && !testDriverEn && !wakeDriverEn;
  endproperty
  a_rq16: assert property (p_rq16) else $error("drivers on in overtemperature"); // [RQ16]
  property p_rq15;
    @(posedge clock) disable iff (srst) (reenable_reg && !busEv && !testEv) |=> !busSc_reg && !testSc_reg;
  endproperty
  a_rq15: assert property (p_rq15) else $error("flags not cleared"); // [RQ15]
  property p_rq12;
    @(posedge clock) disable iff (srst)
      1'b1 |=> wakePullUpEn == $past(cfg_reg[hv_pkg::CFG_OPEN_DIAG_BIT]);
  endproperty
  a_rq12: assert property (p_rq12) else $error("pull-up mismatch"); // [RQ12]
  property p_rq10;
    @(posedge clock) disable iff (srst) (!toEnabled && wakeOut_reg && wakeDriveReq) |=> wakeOut_reg;
  endproperty
  a_rq10: assert property (p_rq10) else $error("wake dropped with timeout off"); // [RQ10]
endmodule

/* hv_line_model.sv */
// behavioural model of the external high voltage lines
`timescale 1ns/1ns
module hv_line_model (
  input  wire logic busDriverEn,
  input  wire logic testDriverEn,
  input  wire logic wakeDriverEn,
  input  wire logic wake_pin,
  input  wire logic wakePullUpEn,
  input  wire logic shortBusReq,
  input  wire logic shortTestReq,
  input  wire logic hotReq,
  input  wire logic shortWakeReq,
  output logic      busShort,
  output logic      testShort,
  output logic      wakeShort,
  output logic      overTemp,
  output logic      wakePinIn,
  output logic      testPinIn
);
  // short passes only while its driver is on, overtemperature passes always
  assign busShort  = shortBusReq & busDriverEn;
  assign testShort = shortTestReq & testDriverEn;
  assign wakeShort = shortWakeReq & wakeDriverEn;
  assign overTemp  = hotReq;
  // an undriven wake line reads low unless the pull-up is enabled
  assign wakePinIn = (wake_pin & wakeDriverEn) | wakePullUpEn;
  assign testPinIn = shortTestReq;
endmodule

/* test_hv_pin_protection_config.sv */
// self-checking bench for the high voltage pin protection block
`timescale 1ns/1ns
module test_hv_pin_protection_config;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        cmdValid = 1'b0;
  logic [3:0]  cmdCode = 4'h0;
  logic [7:0]  cmdWriteData = 8'h00;
  logic [31:0] irqMask = 32'h0000_0000;
  logic        wakeDriveReq = 1'b0;
  logic        shortBusReq = 1'b0;
  logic        shortTestReq = 1'b0;
  logic        hotReq = 1'b0;
  logic        shortWakeReq = 1'b0;
  logic        busShort, testShort, wakeShort, overTemp, wakePinIn, testPinIn;
  logic        coreIrq, busEn, testEn, wakeEn, wakePin, pullUp;
  logic [7:0]  rdData;
  logic [7:0]  pins;
  int          nFail = 0;
  int          testsRun = 0;
  int          cycles = 0;
  localparam logic [31:0] MASK_ON = 32'h0001_0000;
  localparam logic [3:0]  WR = hv_pkg::CMD_WRITE_CFG1;

  assign pins = {2'b00, coreIrq, pullUp, wakePin, wakeEn, testEn, busEn};
  always #5 clock = ~clock;

  hv_pin_protection_config #(.WAKE_TO_CYC(50)) dut (
    .clock(clock), .srst(srst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdWriteData(cmdWriteData), .interrupt_enable_mask(irqMask),
    .wakeDriveReq(wakeDriveReq), .busShort(busShort), .testShort(testShort),
    .wakeShort(wakeShort), .overTemp(overTemp), .wakePinIn(wakePinIn),
    .testPinIn(testPinIn), .hv_indirect_data(rdData), .hv_core_interrupt(coreIrq),
    .busDriverEn(busEn), .testDriverEn(testEn), .wakeDriverEn(wakeEn),
    .wake_pin(wakePin), .wakePullUpEn(pullUp));

  hv_line_model lines (
    .busDriverEn(busEn), .testDriverEn(testEn), .wakeDriverEn(wakeEn),
    .wake_pin(wakePin), .wakePullUpEn(pullUp), .shortBusReq(shortBusReq),
    .shortTestReq(shortTestReq), .hotReq(hotReq), .shortWakeReq(shortWakeReq),
    .busShort(busShort),
    .testShort(testShort), .wakeShort(wakeShort), .overTemp(overTemp),
    .wakePinIn(wakePinIn), .testPinIn(testPinIn));

  // ********************
  // tasks
  // ********************
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic command(input logic [3:0] code, input logic [7:0] data);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdWriteData = data;
    step(1);
    cmdValid = 1'b0;
    step(1);
  endtask

  task automatic readMon(input logic [7:0] exp);
    command(hv_pkg::CMD_READ_MON, 8'h00);
    check(rdData, exp);
  endtask

  task automatic giveVerdict();
    $display("comparisons %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // longest run is about 50500 cycles, most of it the 400 us wake qualification
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      nFail++;
      giveVerdict();
    end
  end

  // ********************
  // sequence
  // ********************
  initial begin
    step(8);
    srst = 1'b0;
    step(2);
    check(pins, 8'h07);
    readMon(8'h00);
    command(WR, 8'h19);
    // test line held high so its readback shows in the monitor
    shortTestReq = 1'b1;
    command(hv_pkg::CMD_READ_CFG1, 8'h00);
    check(rdData, 8'h11);
    check(pins, 8'h17);
    readMon(8'hA0);
    shortTestReq = 1'b0;
    // an undecoded code must leave the configuration alone
    command(4'hF, 8'hFF);
    command(hv_pkg::CMD_READ_CFG1, 8'h00);
    check(rdData, 8'h11);
    command(WR, 8'h00);
    check(pins, 8'h07);
    wakeDriveReq = 1'b1;
    step(5);
    check(pins, 8'h0F);
    step(60);
    check(pins, 8'h07);
    wakeDriveReq = 1'b0;
    command(WR, 8'h02);
    wakeDriveReq = 1'b1;
    step(100);
    check(pins, 8'h0F);
    wakeDriveReq = 1'b0;
    command(WR, 8'h00);
    irqMask = MASK_ON;
    repeat (2) begin
      shortBusReq = 1'b1;
      step(1900);
      shortBusReq = 1'b0;
      step(5);
    end
    readMon(8'h00);
    shortBusReq = 1'b1;
    step(2100);
    check(pins, 8'h26);
    shortBusReq = 1'b0;
    step(50);
    check(pins, 8'h26);
    readMon(8'h04);
    command(WR, 8'h08);
    step(3);
    check(pins, 8'h07);
    readMon(8'h00);
    command(WR, 8'h04);
    irqMask = 32'h0000_0000;
    shortBusReq = 1'b1;
    step(2100);
    check(pins, 8'h07);
    readMon(8'h04);
    irqMask = MASK_ON;
    step(3);
    check(pins, 8'h27);
    shortBusReq = 1'b0;
    // strobe drops the passive-mode bus flag before the test pin run
    command(WR, 8'h08);
    shortTestReq = 1'b1;
    step(2100);
    check(pins, 8'h25);
    readMon(8'h02);
    shortTestReq = 1'b0;
    command(WR, 8'h08);
    step(3);
    check(pins, 8'h07);
    irqMask = 32'h0000_0000;
    hotReq = 1'b1;
    step(10);
    check(pins, 8'h00);
    readMon(8'h40);
    hotReq = 1'b0;
    step(10);
    check(pins, 8'h00);
    command(WR, 8'h08);
    step(3);
    check(pins, 8'h07);
    irqMask = MASK_ON;
    shortWakeReq = 1'b1;
    step(39900);
    check(pins, 8'h07);
    step(200);
    check(pins, 8'h23);
    readMon(8'h01);
    shortWakeReq = 1'b0;
    command(WR, 8'h08);
    step(3);
    check(pins, 8'h07);
    giveVerdict();
  end
endmodule
